// ==== hdl/cps_code_protect.sv ====
`timescale 1ns/1ps

module cps_code_protect
    import cps_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        bulk_erase,
    input  wire logic        fl_req,
    input  wire logic        fl_we,
    input  wire logic        fl_table,
    input  wire logic [23:0] fl_addr,
    input  wire logic [7:0]  fl_wdata,
    input  wire logic [23:0] exec_pc,
    input  wire logic        pgm_rd_req,
    input  wire logic [23:0] pgm_addr,
    input  wire logic        flow_chg,
    input  wire logic [23:0] flow_tgt,
    output logic             ready_q,
    output logic             fl_done_q,
    output logic             fl_ok_q,
    output logic      [7:0]  fl_rdata_q,
    output logic             pgm_done_q,
    output logic             pgm_ok_q,
    output logic             illegal_reset_q
);

    // ------------------------------------------------------------
    // Stored and latched configuration
    // ------------------------------------------------------------
    logic [7:0]  boot_cfg_nv;
    logic [7:0]  gen_cfg_nv;
    logic [2:0]  boot_sel_q;
    logic        boot_wp_q;
    logic        gen_sec_q;
    logic        gen_wp_q;
    logic        load_pend_q;
    logic        cfg_wr_boot;
    logic        cfg_wr_gen;

    cps_cfg_store u_store (
        .clk        (clk),
        .bulk_erase (bulk_erase),
        .wr_boot    (cfg_wr_boot),
        .wr_gen     (cfg_wr_gen),
        .wr_data    (fl_wdata),
        .boot_q     (boot_cfg_nv),
        .gen_q      (gen_cfg_nv)
    );

    // Reset parks the copies at the erased state, then loads them one cycle after release.
    // A synchronous reset may only load constants, so the real load waits for that cycle.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            load_pend_q <= 1'b1;
            boot_sel_q  <= CPS_SEL_NONE;
            boot_wp_q   <= 1'b1;
            gen_sec_q   <= 1'b1;
            gen_wp_q    <= 1'b1;
        end
        else if (load_pend_q)
        begin
            load_pend_q <= 1'b0;
            boot_sel_q  <= boot_cfg_nv[CPS_BOOT_SEL_MSB:CPS_BOOT_SEL_LSB];
            boot_wp_q   <= boot_cfg_nv[CPS_BOOT_WP_BIT];
            gen_sec_q   <= gen_cfg_nv[CPS_GEN_SEC_BIT];
            gen_wp_q    <= gen_cfg_nv[CPS_GEN_WP_BIT];
        end
    end

    // ------------------------------------------------------------
    // Segment decode
    // ------------------------------------------------------------
    cps_sec_type sec_level;
    logic [23:0] boot_end;

    always_comb
    begin
        unique case (boot_sel_q)
            CPS_SEL_NONE:       sec_level = CPS_SEC_NONE;
            CPS_SEL_STD_SMALL,
            CPS_SEL_STD_LARGE:  sec_level = CPS_SEC_STD;
            CPS_SEL_HIGH_SMALL,
            CPS_SEL_HIGH_LARGE: sec_level = CPS_SEC_HIGH;
            // Reserved codes give no boot segment rather than an undefined one.
            default:            sec_level = CPS_SEC_NONE;
        endcase
    end

    wire        boot_on   = (sec_level != CPS_SEC_NONE);
    wire        high_on   = (sec_level == CPS_SEC_HIGH);
    wire        small_sel = (boot_sel_q == CPS_SEL_STD_SMALL)
                          || (boot_sel_q == CPS_SEL_HIGH_SMALL);
    assign      boot_end  = small_sel ? CPS_BOOT_END_SMALL : CPS_BOOT_END_LARGE;

    function automatic logic in_boot(input logic [23:0] a, input logic on,
                                     input logic [23:0] last);
        in_boot = on && (a >= CPS_BOOT_START) && (a <= last);
    endfunction : in_boot

    wire fl_tgt_boot  = in_boot(fl_addr, boot_on, boot_end);
    wire fl_src_boot  = in_boot(exec_pc, boot_on, boot_end);
    wire fl_tgt_cfg   = (fl_addr >= CPS_CFG_SPACE_LO);
    wire pgm_tgt_boot = in_boot(pgm_addr, boot_on, boot_end);
    wire flow_src_gen = !in_boot(exec_pc, boot_on, boot_end);
    wire flow_tgt_boot = in_boot(flow_tgt, boot_on, boot_end);
    wire taken        = !load_pend_q;

    // ------------------------------------------------------------
    // Flash access checks
    // ------------------------------------------------------------
    wire den_cfg   = fl_tgt_cfg && !fl_table;
    wire den_cross = fl_tgt_boot && !fl_src_boot;
    wire den_bwp   = fl_we && fl_tgt_boot && !boot_wp_q;
    wire den_gwp   = fl_we && !fl_tgt_boot && !fl_tgt_cfg && !gen_wp_q;
    wire fl_ok     = !(den_cfg || den_cross || den_bwp || den_gwp);
    wire at_boot_w = (fl_addr == CPS_BOOT_CFG_ADDR);
    wire at_gen_w  = (fl_addr == CPS_GEN_CFG_ADDR);
    wire cfg_cmt   = taken && fl_req && fl_we && fl_ok && fl_tgt_cfg;

    assign cfg_wr_boot = cfg_cmt && at_boot_w;
    assign cfg_wr_gen  = cfg_cmt && at_gen_w;

    wire [7:0] cfg_rd = at_boot_w ? boot_cfg_nv : (at_gen_w ? gen_cfg_nv : 8'h00);
    wire [7:0] rd_sel = (fl_ok && !fl_we && fl_tgt_cfg) ? cfg_rd : 8'h00;

    // ------------------------------------------------------------
    // Programmer reads and flow checks
    // ------------------------------------------------------------
    wire pgm_ok  = pgm_tgt_boot ? 1'b0 : gen_sec_q;
    wire flow_in = high_on && flow_src_gen && flow_tgt_boot;
    wire flow_bad = flow_in && (flow_tgt > CPS_ENTRY_LAST);

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            ready_q         <= 1'b0;
            fl_done_q       <= 1'b0;
            fl_ok_q         <= 1'b0;
            fl_rdata_q      <= 8'h00;
            pgm_done_q      <= 1'b0;
            pgm_ok_q        <= 1'b0;
            illegal_reset_q <= 1'b0;
        end
        else
        begin
            ready_q         <= taken;
            fl_done_q       <= taken && fl_req;
            fl_ok_q         <= taken && fl_req && fl_ok;
            fl_rdata_q      <= (taken && fl_req) ? rd_sel : 8'h00;
            pgm_done_q      <= taken && pgm_rd_req;
            pgm_ok_q        <= taken && pgm_rd_req && pgm_ok;
            illegal_reset_q <= taken && flow_chg && flow_bad;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_cross_block: assert property (
        (taken && fl_req && boot_on && fl_tgt_boot && !fl_src_boot)
            |=> (fl_done_q && !fl_ok_q))
        else $error("boot access from general code was granted");

    chk_boot_self: assert property (
        (taken && fl_req && !fl_we && fl_tgt_boot && fl_src_boot)
            |=> (fl_done_q && fl_ok_q))
        else $error("boot code read of boot memory was refused");

    chk_pgm_boot: assert property (
        (taken && pgm_rd_req && boot_on && (pgm_addr >= CPS_BOOT_START)
            && (pgm_addr <= boot_end)) |=> (pgm_done_q && !pgm_ok_q))
        else $error("programmer read of boot memory was granted");

    chk_pgm_general: assert property (
        (taken && pgm_rd_req && !pgm_tgt_boot) |=> (pgm_ok_q == $past(gen_sec_q)))
        else $error("programmer read of general memory ignores security bit");

    chk_no_boot: assert property (
        (boot_sel_q == CPS_SEL_NONE) |-> (!fl_tgt_boot && !pgm_tgt_boot && !flow_tgt_boot))
        else $error("boot segment decoded while none is configured");

    chk_gen_locked: assert property (
        (taken && pgm_rd_req && !gen_sec_q) |=> !pgm_ok_q)
        else $error("protected general memory was read by programmer");

    chk_entry_ok: assert property (
        (taken && flow_chg && high_on && flow_src_gen && (flow_tgt >= CPS_BOOT_START)
            && (flow_tgt <= CPS_ENTRY_LAST)) |=> !illegal_reset_q)
        else $error("legal boot entry raised a reset");

    chk_entry_bad: assert property (
        (taken && flow_chg && high_on && flow_src_gen && (flow_tgt > CPS_ENTRY_LAST)
            && (flow_tgt <= boot_end)) |=> illegal_reset_q
            ##1 (!illegal_reset_q || $past(flow_chg)))
        else $error("illegal boot entry did not give one reset pulse");

    chk_cfg_table: assert property (
        (taken && fl_req && !fl_table && (fl_addr >= CPS_CFG_SPACE_LO)) |=> !fl_ok_q)
        else $error("configuration space reached without a table access");

    chk_boot_wp: assert property (
        (taken && fl_req && fl_we && fl_tgt_boot && !boot_wp_q) |=> !fl_ok_q)
        else $error("write to protected boot memory was granted");

    chk_gen_wp: assert property (
        (taken && fl_req && fl_we && !fl_tgt_boot && !fl_tgt_cfg && !gen_wp_q) |=> !fl_ok_q)
        else $error("write to protected general memory was granted");

    chk_clear_only: assert property (
        !bulk_erase |=> ((boot_cfg_nv & ~$past(boot_cfg_nv)) == 8'h00)
            && ((gen_cfg_nv & ~$past(gen_cfg_nv)) == 8'h00))
        else $error("configuration bit rose without bulk erase");

    chk_latch_hold: assert property (
        taken |=> ($stable(boot_sel_q) && $stable(gen_sec_q) && $stable(boot_wp_q)
            && $stable(gen_wp_q)))
        else $error("latched settings changed before reset");

    // Every answer follows a taken request by one edge, so each check looks one cycle on.
    chk_pgm_answer: assert property (
        (taken && pgm_rd_req) |=> pgm_done_q)
        else $error("programmer read got no answer");

    chk_boot_cfg_read: assert property (
        (taken && fl_req && fl_table && !fl_we && at_boot_w)
            |=> (fl_done_q && fl_ok_q && (fl_rdata_q == $past(boot_cfg_nv))))
        else $error("boot word read returned a wrong byte");

    chk_gen_cfg_read: assert property (
        (taken && fl_req && fl_table && !fl_we && at_gen_w)
            |=> (fl_done_q && fl_ok_q && (fl_rdata_q == $past(gen_cfg_nv))))
        else $error("general word read returned a wrong byte");

    chk_table_read: assert property (
        (taken && fl_req && fl_table && !fl_we && fl_tgt_cfg) |=> (fl_done_q && fl_ok_q))
        else $error("table read of configuration space was refused");

    // A write may only clear bits, so the stored byte is the old byte masked by the data.
    chk_cfg_clear: assert property (
        (taken && fl_req && fl_we && fl_table && at_boot_w && !bulk_erase)
            |=> (boot_cfg_nv == ($past(boot_cfg_nv) & $past(fl_wdata))))
        else $error("boot word write did not clear the written bits");

    chk_boot_write_open: assert property (
        (taken && fl_req && fl_we && fl_tgt_boot && fl_src_boot && boot_wp_q) |=> fl_ok_q)
        else $error("open boot memory write was refused");

    chk_gen_write_open: assert property (
        (taken && fl_req && fl_we && !fl_tgt_boot && !fl_tgt_cfg && gen_wp_q) |=> fl_ok_q)
        else $error("open general memory write was refused");

    chk_std_free: assert property (
        (taken && flow_chg && !high_on) |=> !illegal_reset_q)
        else $error("flow change raised a reset outside high security");

    chk_boot_jump: assert property (
        (taken && flow_chg && !flow_src_gen) |=> !illegal_reset_q)
        else $error("flow change from boot code raised a reset");

    // The load cycle must stay silent, or a request would be judged on erased settings.
    chk_load_quiet: assert property (
        !taken |=> (!ready_q && !fl_done_q && !pgm_done_q && !illegal_reset_q))
        else $error("answer given during the settings load cycle");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    cov_bad_entry:  cover property (taken && flow_chg && flow_bad ##1 illegal_reset_q);
    cov_cross_deny: cover property (taken && fl_req && den_cross ##1 !fl_ok_q);
    cov_cfg_write:  cover property (cfg_wr_boot ##1 cfg_wr_gen);
    cov_entry_ok:   cover property (taken && flow_chg && flow_in && !flow_bad ##1 !illegal_reset_q);
    cov_prog_deny:  cover property (taken && pgm_rd_req && !pgm_ok ##1 (pgm_done_q && !pgm_ok_q));

endmodule : cps_code_protect

// ==== hdl/cps_pkg.sv ====
package cps_pkg;

    // ------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------
    localparam int unsigned CPS_ADDR_W         = 24;
    localparam int unsigned CPS_CFG_W          = 8;
    localparam logic [23:0] CPS_BOOT_CFG_ADDR  = 24'hF80000;
    localparam logic [23:0] CPS_GEN_CFG_ADDR   = 24'hF80004;
    localparam logic [23:0] CPS_CFG_SPACE_LO   = 24'h800000;
    localparam logic [23:0] CPS_BOOT_START     = 24'h000200;
    localparam logic [23:0] CPS_BOOT_END_SMALL = 24'h000AFE;
    localparam logic [23:0] CPS_BOOT_END_LARGE = 24'h0015FE;
    localparam logic [23:0] CPS_ENTRY_LAST     = 24'h00023F;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CPS_BOOT_SEL_LSB   = 1;
    localparam int unsigned CPS_BOOT_SEL_MSB   = 3;
    localparam int unsigned CPS_BOOT_WP_BIT    = 0;
    localparam int unsigned CPS_GEN_SEC_BIT    = 1;
    localparam int unsigned CPS_GEN_WP_BIT     = 0;

    // ------------------------------------------------------------
    // Security codes and erased values
    // ------------------------------------------------------------
    localparam logic [2:0] CPS_SEL_NONE        = 3'h7;
    localparam logic [2:0] CPS_SEL_STD_SMALL   = 3'h6;
    localparam logic [2:0] CPS_SEL_STD_LARGE   = 3'h5;
    localparam logic [2:0] CPS_SEL_HIGH_SMALL  = 3'h2;
    localparam logic [2:0] CPS_SEL_HIGH_LARGE  = 3'h1;
    localparam logic [7:0] CPS_BOOT_CFG_ERASED = 8'h0F;
    localparam logic [7:0] CPS_GEN_CFG_ERASED  = 8'h03;

    typedef enum logic [1:0] {
        CPS_SEC_NONE,
        CPS_SEC_STD,
        CPS_SEC_HIGH
    } cps_sec_type;

endpackage : cps_pkg

// ==== hdl/cps_cfg_store.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// Non-volatile configuration bytes
// ------------------------------------------------------------
module cps_cfg_store
    import cps_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       bulk_erase,
    input  wire logic       wr_boot,
    input  wire logic       wr_gen,
    input  wire logic [7:0] wr_data,
    output logic      [7:0] boot_q,
    output logic      [7:0] gen_q
);

    // Cells are non-volatile, so no reset touches them; only erase returns bits to one.
    // Programming can only clear bits, and erase wins over a write in the same cycle.
    always_ff @(posedge clk)
    begin
        if (bulk_erase)
        begin
            boot_q <= CPS_BOOT_CFG_ERASED;
            gen_q  <= CPS_GEN_CFG_ERASED;
        end
        else
        begin
            if (wr_boot)
                boot_q <= boot_q & wr_data;
            if (wr_gen)
                gen_q <= gen_q & wr_data;
        end
    end

endmodule : cps_cfg_store

// ==== dv/cps_prog_model.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// Serial programmer on the far side of the read port
// ------------------------------------------------------------
module cps_prog_model
(
    input  wire logic        clk,
    output logic             pgm_rd_req,
    output logic      [23:0] pgm_addr
);
    initial
    begin
        pgm_rd_req = 1'b0;
        pgm_addr   = 24'h000000;
    end

    // The programmer only reads; it never tries to set protection bits back to one.
    // The address is inverted after the request so that a late sample sees a wrong value.
    task automatic rd(input logic [23:0] addr);
        @(posedge clk);
        pgm_rd_req <= 1'b1;
        pgm_addr   <= addr;
        @(posedge clk);
        pgm_rd_req <= 1'b0;
        pgm_addr   <= ~addr;
    endtask : rd
endmodule : cps_prog_model

// ==== dv/cps_code_protect_test.sv ====
`timescale 1ns/1ps

module cps_code_protect_test
    import cps_pkg::*;
;
    logic        clk, resetn, bulk_erase, fl_req, fl_we, fl_table, flow_chg, pgm_rd_req;
    logic [23:0] fl_addr, exec_pc, flow_tgt, pgm_addr;
    logic [7:0]  fl_wdata, fl_rdata_q;
    logic        ready_q, fl_done_q, fl_ok_q, pgm_done_q, pgm_ok_q, illegal_reset_q;
    int          err_count, num_checks;
    logic [9:0]  r;

    cps_code_protect cps_code_protect_i (.clk(clk), .resetn(resetn), .bulk_erase(bulk_erase),
        .fl_req(fl_req), .fl_we(fl_we), .fl_table(fl_table), .fl_addr(fl_addr),
        .fl_wdata(fl_wdata), .exec_pc(exec_pc), .pgm_rd_req(pgm_rd_req), .pgm_addr(pgm_addr),
        .flow_chg(flow_chg), .flow_tgt(flow_tgt), .ready_q(ready_q), .fl_done_q(fl_done_q),
        .fl_ok_q(fl_ok_q), .fl_rdata_q(fl_rdata_q), .pgm_done_q(pgm_done_q),
        .pgm_ok_q(pgm_ok_q), .illegal_reset_q(illegal_reset_q));

    cps_prog_model cps_prog_model_i (.clk(clk), .pgm_rd_req(pgm_rd_req), .pgm_addr(pgm_addr));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Reset is long, then the ready flag is awaited under a bound.
    task automatic rst(input logic erase);
        @(posedge clk);
        resetn     <= 1'b0;
        bulk_erase <= erase;
        repeat (16) @(posedge clk);
        resetn     <= 1'b1;
        bulk_erase <= 1'b0;
        for (int n = 0; n < 8 && ready_q !== 1'b1; n++)
        begin
            @(posedge clk);
            #1;
        end
        chk("ready", {9'h000, ready_q}, 10'h001);
    endtask : rst

    task automatic fl(input logic we, input logic tbl, input logic [23:0] a,
                      input logic [23:0] pc, input logic [7:0] wd);
        @(posedge clk);
        fl_req   <= 1'b1;
        fl_we    <= we;
        fl_table <= tbl;
        fl_addr  <= a;
        exec_pc  <= pc;
        fl_wdata <= wd;
        @(posedge clk);
        fl_req   <= 1'b0;
        #1 r = {fl_done_q, fl_ok_q, fl_rdata_q};
    endtask : fl

    task automatic flow(input logic [23:0] pc, input logic [23:0] tgt);
        @(posedge clk);
        flow_chg <= 1'b1;
        exec_pc  <= pc;
        flow_tgt <= tgt;
        @(posedge clk);
        flow_chg <= 1'b0;
        #1 r = {9'h000, illegal_reset_q};
    endtask : flow

    task automatic pgm(input logic [23:0] a);
        cps_prog_model_i.rd(a);
        #1 r = {8'h00, pgm_done_q, pgm_ok_q};
    endtask : pgm

    task automatic setup(input logic [7:0] bw, input logic [7:0] gw);
        rst(1'b1);
        fl(1'b1, 1'b1, CPS_BOOT_CFG_ADDR, 24'h002000, bw);
        fl(1'b1, 1'b1, CPS_GEN_CFG_ADDR, 24'h002000, gw);
        rst(1'b0);
    endtask : setup

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_config();
        rst(1'b1);
        fl(1'b0, 1'b1, CPS_BOOT_CFG_ADDR, 24'h002000, 8'h00);
        chk("boot byte", r, {2'b11, CPS_BOOT_CFG_ERASED});
        fl(1'b0, 1'b1, CPS_GEN_CFG_ADDR, 24'h002000, 8'h00);
        chk("gen byte", r, {2'b11, CPS_GEN_CFG_ERASED});
        fl(1'b0, 1'b0, CPS_BOOT_CFG_ADDR, 24'h002000, 8'h00);
        chk("untabled read", r, 10'h200);
        fl(1'b1, 1'b1, CPS_BOOT_CFG_ADDR, 24'h002000, 8'h0B);
        fl(1'b1, 1'b1, CPS_BOOT_CFG_ADDR, 24'h002000, 8'hFF);
        fl(1'b0, 1'b1, CPS_BOOT_CFG_ADDR, 24'h002000, 8'h00);
        chk("bits stay clear", r, 10'h30B);
        fl(1'b1, 1'b1, CPS_GEN_CFG_ADDR, 24'h002000, 8'h00);
        rst(1'b0);
        pgm(24'h000300);
        chk("prog boot read", r, 10'h002);
        pgm(24'h002000);
        chk("prog gen read", r, 10'h002);
        fl(1'b0, 1'b0, 24'h000300, 24'h002000, 8'h00);
        chk("gen reads boot", r, 10'h200);
        fl(1'b1, 1'b0, 24'h000300, 24'h002000, 8'h00);
        chk("gen writes boot", r, 10'h200);
        fl(1'b0, 1'b0, 24'h000300, 24'h000400, 8'h00);
        chk("boot reads boot", r, 10'h300);
        fl(1'b1, 1'b0, 24'h000300, 24'h000400, 8'h00);
        chk("boot writes boot", r, 10'h300);
        fl(1'b0, 1'b0, 24'h0015FE, 24'h002000, 8'h00);
        chk("last boot word", r, 10'h200);
        fl(1'b0, 1'b0, 24'h001600, 24'h002000, 8'h00);
        chk("past boot end", r, 10'h300);
        fl(1'b1, 1'b0, 24'h002000, 24'h002000, 8'h00);
        chk("gen write locked", r, 10'h200);
        flow(24'h002000, 24'h000240);
        chk("std entry", r, 10'h000);
        fl(1'b1, 1'b1, CPS_BOOT_CFG_ADDR, 24'h002000, 8'h03);
        flow(24'h002000, 24'h000240);
        chk("latched level", r, 10'h000);
        rst(1'b0);
        flow(24'h002000, 24'h000240);
        chk("high entry", r, 10'h001);
        flow(24'h000300, 24'h000400);
        chk("boot inner jump", r, 10'h000);
        $display("test config done");
    endtask : test_config

    task automatic test_write_protect();
        setup(8'h0C, 8'h03);
        fl(1'b1, 1'b0, 24'h000300, 24'h000400, 8'h00);
        chk("boot write locked", r, 10'h200);
        fl(1'b1, 1'b0, 24'h002000, 24'h002000, 8'h00);
        chk("gen write open", r, 10'h300);
        pgm(24'h002000);
        chk("prog gen open", r, 10'h003);
        $display("test write protect done");
    endtask : test_write_protect

    task automatic test_codes();
        logic [2:0] sel [8];
        logic [2:0] s;
        logic       hi, big, on;
        sel = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
        for (int i = 0; i < 8; i++)
        begin
            s   = sel[i];
            hi  = (s == CPS_SEL_HIGH_SMALL) || (s == CPS_SEL_HIGH_LARGE);
            big = (s == CPS_SEL_STD_LARGE) || (s == CPS_SEL_HIGH_LARGE);
            on  = hi || (s == CPS_SEL_STD_SMALL) || big;
            setup({4'h0, s, 1'b1}, 8'h03);
            pgm(24'h000300);
            chk("prog boot code", r, {8'h00, 1'b1, ~on});
            fl(1'b0, 1'b0, 24'h001000, 24'h002000, 8'h00);
            chk("boot size", r, {1'b1, ~big, 8'h00});
            flow(24'h002000, 24'h00023F);
            chk("last entry", r, 10'h000);
            flow(24'h002000, 24'h000240);
            chk("entry past range", r, {9'h000, hi});
        end
        $display("test codes done");
    endtask : test_codes

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    initial
    begin
        {resetn, bulk_erase, fl_req, fl_we, fl_table, flow_chg} = 6'h00;
        {fl_addr, exec_pc, flow_tgt, fl_wdata} = 80'h0;
        err_count  = 0;
        num_checks = 0;
        @(posedge clk);
        test_config();
        test_write_protect();
        test_codes();
        close_out();
    end

    // Whole run is about 550 cycles; the limit leaves wide margin.
    initial
    begin
        #200000;
        err_count++;
        close_out();
    end
endmodule : cps_code_protect_test
